// >>> hdl/sfs_pkg.sv
package sfs_pkg;

  // Stop-method selection field encodings
  localparam logic [3:0] STOP_METHOD_DB    = 4'h0;
  localparam logic [3:0] STOP_METHOD_DECEL = 4'h2;
  localparam logic [3:0] STOP_METHOD_RST   = STOP_METHOD_DECEL;

  // Register map on the plain port (word index)
  localparam int         ADDR_W            = 4;
  localparam logic [3:0] ADDR_CTRL         = 4'h0;
  localparam logic [3:0] ADDR_ZERO_LEVEL   = 4'h1;
  localparam logic [3:0] ADDR_DECEL_TIME   = 4'h2;
  localparam logic [3:0] ADDR_RATED_SPEED  = 4'h3;
  localparam logic [3:0] ADDR_STATUS       = 4'h4;
  localparam logic [3:0] ADDR_CMD_SPEED    = 4'h5;
  localparam logic [3:0] ADDR_WARN_CODE    = 4'h6;

  // Control register field positions
  localparam int CTRL_METHOD_LSB = 0;
  localparam int CTRL_DB_FIT_BIT = 4;

  // Status register field positions
  localparam int ST_STATE_LSB  = 0;
  localparam int ST_BASE_BIT   = 4;
  localparam int ST_DB_BIT     = 5;
  localparam int ST_BRAKE_BIT  = 6;
  localparam int ST_FAULT_BIT  = 7;
  localparam int ST_WARN_BIT   = 8;
  localparam int ST_REJECT_BIT = 9;

  // Reset values: speeds in r/min (or mm/s), times in ms
  localparam logic [15:0] ZERO_LEVEL_RST  = 16'h0032;   // 50
  localparam logic [15:0] DECEL_TIME_RST  = 16'h0064;   // 100 ms
  localparam logic [15:0] RATED_SPEED_RST = 16'h0bb8;   // plain default
  localparam logic [15:0] WARN_CODE       = 16'h00e6;

  // One ramp step each millisecond at the 40 MHz clock
  localparam int CLK_HZ       = 40000000;
  localparam int TICK_MS      = 1;
  localparam int TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;

  localparam int SPD_W  = 16;
  localparam int FRAC_W = 16;

  typedef enum logic [2:0] {
    SFS_RUN     = 3'b000,
    SFS_DECEL   = 3'b001,
    SFS_WAITZ   = 3'b010,
    SFS_DBSTOP  = 3'b011,
    SFS_STOPPED = 3'b100
  } sfs_state_t;

  typedef struct packed {
    logic                   wr;
    logic                   rd;
    logic [ADDR_W-1:0]      addr;
    logic [15:0]            wdata;
  } sfs_bus_t;

  typedef struct packed {
    logic alarm;
    logic alarm_no_decel;
    logic alarm_db;
    logic comm_lost;
    logic comm_lost_db;
  } sfs_fault_t;

endpackage : sfs_pkg

// >>> hdl/sfs_sequencer.sv
//
// Operation
// - Input b drop starts deceleration when enabled
// - Method field: 0 brake, 2 decel; reset 2
// - Ramp done and below zero level: brake
// - Zero speed level configurable, default 50
// - Decel time configurable, default 100 ms
// - Alarm with decel: ramp, drop interlock, fault
// - Brake-stop alarm: drop outputs, brake at once
// - Decel disabled: alarm, comm loss brake immediately
// - Comm loss ramps; may also brake
// - Warning code raised during deceleration
// - Network quick stop acts like input b with method 2, like input a with method 0
// - No deceleration in torque modes
// - Non-decel alarms skip the ramp
// - Reject motion commands while held stopped
// - Brake alarm during ramp brakes at once
// - Without dynamic brake, coast instead
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`default_nettype none

module sfs_sequencer (
  input  wire logic                       mclk,
  input  wire logic                       reset_n,
  input  wire sfs_pkg::sfs_bus_t          bus,
  output logic [15:0]                     rdata,
  input  wire logic                       forced_stop_input_a,
  input  wire logic                       forced_stop_input_b,
  input  wire logic                       servo_on_cmd,
  input  wire logic                       quick_stop_cmd,
  input  wire logic                       torque_mode,
  input  wire logic                       motion_cmd_valid,
  input  wire sfs_pkg::sfs_fault_t        fault,
  input  wire logic [15:0]                motor_speed,
  output logic [15:0]                     cmd_speed,
  output logic                            motion_cmd_accept,
  output logic                            base_drive_on,
  output logic                            dyn_brake_on,
  output logic                            brake_interlock_out,
  output logic                            fault_output,
  output logic                            zero_speed_detect,
  output logic                            forced_stop_warning
);

  logic [1:0]          em_a_sync_reg;
  logic [1:0]          em_b_sync_reg;
  logic [3:0]          stop_method_field_reg;
  logic                db_fitted_reg;
  logic [15:0]         zero_speed_level_reg;
  logic [15:0]         stop_decel_time_reg;
  logic [15:0]         rated_speed_reg;
  sfs_pkg::sfs_state_t state_reg;
  sfs_pkg::sfs_state_t state_next;
  logic [31:0]         speed_acc_reg;
  logic [31:0]         step_reg;
  logic [31:0]         tick_cnt_reg;
  logic                tick;
  logic                decel_en;
  logic                soft_stop_req;
  logic                hard_stop_req;
  logic                stop_req;
  logic [15:0]         status;

  // Pin inputs pass two flops; only the second stage is read
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      em_a_sync_reg <= 2'h3;
    end else begin
      em_a_sync_reg <= {em_a_sync_reg[0], forced_stop_input_a};
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      em_b_sync_reg <= 2'h3;
    end else begin
      em_b_sync_reg <= {em_b_sync_reg[0], forced_stop_input_b};
    end
  end

  // Deceleration only with method 2 and outside torque modes
  assign decel_en = (stop_method_field_reg == sfs_pkg::STOP_METHOD_DECEL)
                    && !torque_mode;

  always_comb begin
    soft_stop_req = 1'b0;
    hard_stop_req = 1'b0;
    if (stop_method_field_reg == sfs_pkg::STOP_METHOD_DECEL) begin
      soft_stop_req = !em_b_sync_reg[1] || quick_stop_cmd;
    end else begin
      hard_stop_req = !em_a_sync_reg[1] || quick_stop_cmd;
    end
    if (fault.alarm || fault.comm_lost) begin
      if (decel_en && !(fault.alarm && fault.alarm_no_decel)) begin
        soft_stop_req = 1'b1;
      end else begin
        hard_stop_req = 1'b1;
      end
    end
    if (fault.alarm && fault.alarm_db) begin
      hard_stop_req = 1'b1;
    end
    if (fault.comm_lost && fault.comm_lost_db) begin
      hard_stop_req = 1'b1;
    end
    if (!decel_en && soft_stop_req) begin
      hard_stop_req = 1'b1;
    end
  end

  assign stop_req = soft_stop_req || hard_stop_req;

  // Register writes
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stop_method_field_reg <= sfs_pkg::STOP_METHOD_RST;
      db_fitted_reg         <= 1'b1;
      zero_speed_level_reg  <= sfs_pkg::ZERO_LEVEL_RST;
      stop_decel_time_reg   <= sfs_pkg::DECEL_TIME_RST;
      rated_speed_reg       <= sfs_pkg::RATED_SPEED_RST;
    end else if (bus.wr) begin
      unique case (bus.addr)
        sfs_pkg::ADDR_CTRL: begin
          // Only the two legal method codes are kept; others leave the field alone
          if (bus.wdata[sfs_pkg::CTRL_METHOD_LSB +: 4] == sfs_pkg::STOP_METHOD_DB ||
              bus.wdata[sfs_pkg::CTRL_METHOD_LSB +: 4] == sfs_pkg::STOP_METHOD_DECEL) begin
            stop_method_field_reg <= bus.wdata[sfs_pkg::CTRL_METHOD_LSB +: 4];
          end
          db_fitted_reg <= bus.wdata[sfs_pkg::CTRL_DB_FIT_BIT];
        end
        sfs_pkg::ADDR_ZERO_LEVEL:  zero_speed_level_reg <= bus.wdata;
        sfs_pkg::ADDR_DECEL_TIME: begin
          // Zero is ignored: it would make the step division meaningless
          if (bus.wdata != 16'h0000) begin
            stop_decel_time_reg <= bus.wdata;
          end
        end
        sfs_pkg::ADDR_RATED_SPEED: rated_speed_reg <= bus.wdata;
        default: ;
      endcase
    end
  end

  // Status word for software; the reject bit mirrors any state but RUN
  always_comb begin
    status                             = 16'h0000;
    status[sfs_pkg::ST_STATE_LSB +: 3] = state_reg;
    status[sfs_pkg::ST_BASE_BIT]       = base_drive_on;
    status[sfs_pkg::ST_DB_BIT]         = dyn_brake_on;
    status[sfs_pkg::ST_BRAKE_BIT]      = brake_interlock_out;
    status[sfs_pkg::ST_FAULT_BIT]      = fault_output;
    status[sfs_pkg::ST_WARN_BIT]       = forced_stop_warning;
    status[sfs_pkg::ST_REJECT_BIT]     = (state_reg != sfs_pkg::SFS_RUN);
  end

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 16'h0000;
    end else if (bus.rd) begin
      unique case (bus.addr)
        sfs_pkg::ADDR_CTRL:        rdata <= {11'h000, db_fitted_reg, stop_method_field_reg};
        sfs_pkg::ADDR_ZERO_LEVEL:  rdata <= zero_speed_level_reg;
        sfs_pkg::ADDR_DECEL_TIME:  rdata <= stop_decel_time_reg;
        sfs_pkg::ADDR_RATED_SPEED: rdata <= rated_speed_reg;
        sfs_pkg::ADDR_STATUS:      rdata <= status;
        sfs_pkg::ADDR_CMD_SPEED:   rdata <= cmd_speed;
        sfs_pkg::ADDR_WARN_CODE:   rdata <= forced_stop_warning ? sfs_pkg::WARN_CODE : 16'h0000;
        default:                   rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end

  // Millisecond tick for the ramp
  // Free-running, so the first ramp step falls anywhere within the first ms
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_reg <= 32'h00000000;
    end else if (tick_cnt_reg == 32'(sfs_pkg::TICK_CYCLES - 1)) begin
      tick_cnt_reg <= 32'h00000000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
    end
  end

  assign tick = (tick_cnt_reg == 32'(sfs_pkg::TICK_CYCLES - 1));

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      sfs_pkg::SFS_RUN: begin
        if (hard_stop_req) begin
          state_next = sfs_pkg::SFS_DBSTOP;
        end else if (soft_stop_req) begin
          state_next = sfs_pkg::SFS_DECEL;
        end
      end
      sfs_pkg::SFS_DECEL: begin
        if (hard_stop_req) begin
          state_next = sfs_pkg::SFS_DBSTOP;
        end else if (speed_acc_reg[31:16] == 16'h0000) begin
          state_next = sfs_pkg::SFS_WAITZ;
        end
      end
      sfs_pkg::SFS_WAITZ: begin
        if (hard_stop_req || motor_speed < zero_speed_level_reg) begin
          state_next = sfs_pkg::SFS_DBSTOP;
        end
      end
      sfs_pkg::SFS_DBSTOP: begin
        if (motor_speed < zero_speed_level_reg) begin
          state_next = sfs_pkg::SFS_STOPPED;
        end
      end
      sfs_pkg::SFS_STOPPED: begin
        // Restart only once every cause is gone and servo-on is high
        if (!stop_req && servo_on_cmd) begin
          state_next = sfs_pkg::SFS_RUN;
        end
      end
      default: state_next = sfs_pkg::SFS_DBSTOP;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= sfs_pkg::SFS_STOPPED;
    end else begin
      state_reg <= state_next;
    end
  end

  // Ramp: step per ms = rated / time in 16.16 fixed point
  // The step is frozen during a ramp; a new time only applies to the next stop
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      step_reg <= 32'h00000000;
    end else if (state_reg != sfs_pkg::SFS_DECEL) begin
      step_reg <= {rated_speed_reg, 16'h0000} / {16'h0000, stop_decel_time_reg};
    end
  end

  // Start speed is captured every cycle outside the ramp
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      speed_acc_reg <= 32'h00000000;
    end else if (state_reg != sfs_pkg::SFS_DECEL) begin
      speed_acc_reg <= {motor_speed, 16'h0000};
    end else if (tick) begin
      if (speed_acc_reg > step_reg) begin
        speed_acc_reg <= speed_acc_reg - step_reg;
      end else begin
        speed_acc_reg <= 32'h00000000;
      end
    end
  end

  // Outputs but the fault and zero-speed flags come from flops fed by the next state, so they move with it
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_speed <= 16'h0000;
    end else begin
      cmd_speed <= (state_next == sfs_pkg::SFS_DECEL) ? speed_acc_reg[31:16] : 16'h0000;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      base_drive_on <= 1'b0;
    end else begin
      base_drive_on <= (state_next == sfs_pkg::SFS_RUN) ||
                       (state_next == sfs_pkg::SFS_DECEL) ||
                       (state_next == sfs_pkg::SFS_WAITZ);
    end
  end

  // With no brake fitted the stage just goes off and the motor coasts
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dyn_brake_on <= 1'b0;
    end else begin
      dyn_brake_on <= db_fitted_reg &&
                      ((state_next == sfs_pkg::SFS_DBSTOP) ||
                       (state_next == sfs_pkg::SFS_STOPPED));
    end
  end

  // Interlock follows the alarm directly, so it drops even on a ramping alarm
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      brake_interlock_out <= 1'b0;
    end else begin
      brake_interlock_out <= (state_next == sfs_pkg::SFS_RUN) && !fault.alarm;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      fault_output <= 1'b0;
    end else begin
      fault_output <= !fault.alarm;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      forced_stop_warning <= 1'b0;
    end else begin
      forced_stop_warning <= (state_next == sfs_pkg::SFS_DECEL) ||
                             (state_next == sfs_pkg::SFS_WAITZ);
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      motion_cmd_accept <= 1'b0;
    end else begin
      motion_cmd_accept <= motion_cmd_valid && (state_next == sfs_pkg::SFS_RUN);
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      zero_speed_detect <= 1'b0;
    end else begin
      zero_speed_detect <= motor_speed < zero_speed_level_reg;
    end
  end

endmodule // sfs_sequencer

`default_nettype wire

// >>> dv/sfs_sequencer_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module sfs_sequencer_monitor (
  input wire logic                mclk,
  input wire logic                reset_n,
  input wire logic                torque_mode,
  input wire sfs_pkg::sfs_fault_t fault,
  input wire logic [15:0]         cmd_speed,
  input wire logic                motion_cmd_accept,
  input wire logic                base_drive_on,
  input wire logic                dyn_brake_on,
  input wire logic                brake_interlock_out,
  input wire logic                fault_output,
  input wire logic                forced_stop_warning
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  property p_warn; forced_stop_warning |-> base_drive_on && !brake_interlock_out; endproperty
  a_warn: assert property (p_warn) else $error("warning outside ramp");
  property p_db; dyn_brake_on |-> !base_drive_on; endproperty
  a_db: assert property (p_db) else $error("brake with drive on");
  property p_cmd0; !forced_stop_warning |-> cmd_speed == 16'h0000; endproperty
  a_cmd0: assert property (p_cmd0) else $error("speed command outside ramp");
  property p_down; forced_stop_warning && $past(forced_stop_warning)
    |-> cmd_speed <= $past(cmd_speed); endproperty
  a_down: assert property (p_down) else $error("ramp went up");
  property p_torq; $rose(forced_stop_warning) |-> !$past(torque_mode); endproperty
  a_torq: assert property (p_torq) else $error("ramp in torque mode");
  property p_adb; fault.alarm && fault.alarm_db |=> !base_drive_on && !brake_interlock_out;
  endproperty
  a_adb: assert property (p_adb) else $error("brake alarm not immediate");
  property p_alm; fault.alarm |=> !fault_output && !brake_interlock_out; endproperty
  a_alm: assert property (p_alm) else $error("outputs kept on alarm");
  property p_cdb; fault.comm_lost && fault.comm_lost_db |=> !base_drive_on; endproperty
  a_cdb: assert property (p_cdb) else $error("link loss brake late");
  property p_nod; fault.alarm && fault.alarm_no_decel |=> !forced_stop_warning && !base_drive_on;
  endproperty
  a_nod: assert property (p_nod) else $error("ramp on no-ramp alarm");
  property p_rej; dyn_brake_on || forced_stop_warning |-> !motion_cmd_accept; endproperty
  a_rej: assert property (p_rej) else $error("command taken while stopping");
endmodule // sfs_sequencer_monitor
bind sfs_sequencer sfs_sequencer_monitor u_mon (.*);
`default_nettype wire

// >>> dv/sfs_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module sfs_ctrl_model (
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic stop_req,
  input  wire logic qs_req,
  input  wire logic off_req,
  output logic      forced_stop_input_b,
  output logic      servo_on_cmd,
  output logic      quick_stop_cmd
);
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      forced_stop_input_b <= 1'b1;
      servo_on_cmd        <= 1'b0;
      quick_stop_cmd      <= 1'b0;
    end else begin
      // Held for the whole stop, never pulsed as a drive switch
      forced_stop_input_b <= !(stop_req || off_req);
      quick_stop_cmd      <= qs_req;
      // Servo-on only falls once input b is already low
      servo_on_cmd        <= !off_req || forced_stop_input_b;
    end
  end
endmodule // sfs_ctrl_model
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic                mclk = 1'b0;
  logic                reset_n = 1'b0;
  logic                stop_req = 1'b0;
  logic                qs_req = 1'b0;
  logic                off_req = 1'b0;
  logic                forced_stop_input_a = 1'b1;
  logic                torque_mode = 1'b0;
  logic                motion_cmd_valid = 1'b0;
  logic [15:0]         motor_speed = 16'h0000;
  sfs_pkg::sfs_bus_t   bus = '0;
  sfs_pkg::sfs_fault_t fault = '0;
  logic forced_stop_input_b, servo_on_cmd, quick_stop_cmd, motion_cmd_accept;
  logic base_drive_on, dyn_brake_on, brake_interlock_out, fault_output;
  logic zero_speed_detect, forced_stop_warning;
  logic [15:0]         rdata, cmd_speed, last;
  int                  n_fail = 0, checks = 0, i, exp_spd;
  integer              seed = 32'hde6f60f4;
  always #12.5 mclk = ~mclk;
  sfs_ctrl_model u_ctrl (.*);
  sfs_sequencer  u_dut (.*);
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic cond(input int s);
    case (s)
      0: return base_drive_on === 1'b1 && dyn_brake_on === 1'b0;
      1: return forced_stop_warning === 1'b1 || base_drive_on === 1'b0;
      2: return cmd_speed !== last;
      default: return dyn_brake_on === 1'b1;
    endcase
  endfunction
  task automatic wait_on(input int s, input int lim);
    for (i = 0; i < lim && !cond(s); i++) begin
      @(posedge mclk);
      #1;
    end
    if (!cond(s)) begin
      n_fail++;
      $display("mismatch at %0t: wait ran out", $time);
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge mclk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // Warning, drive, brake as expected; interlock is always off once stopping
  task automatic look(input logic [2:0] e);
    repeat (2) @(posedge mclk);
    #1 chk({12'h000, forced_stop_warning, base_drive_on, dyn_brake_on, brake_interlock_out},
           {12'h000, e, 1'b0});
  endtask
  task automatic acc(input logic run);
    repeat (4) begin
      @(posedge mclk);
      motion_cmd_valid <= 1'($random(seed));
      @(posedge mclk);
      #1 chk({15'h0000, motion_cmd_accept}, {15'h0000, motion_cmd_valid & run});
    end
  endtask
  task automatic fail_in(input logic [4:0] f);
    @(posedge mclk);
    fault <= f;
  endtask
  task automatic run_up;
    @(posedge mclk);
    fault <= '0;
    stop_req <= 1'b0;
    qs_req <= 1'b0;
    torque_mode <= 1'b0;
    forced_stop_input_a <= 1'b1;
    motor_speed <= 16'h0000;
    wait_on(0, 20);
    chk({14'h0000, brake_interlock_out, fault_output}, 16'h0003);
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    rd(sfs_pkg::ADDR_CTRL, 16'h0012);
    rd(sfs_pkg::ADDR_ZERO_LEVEL, 16'h0032);
    rd(sfs_pkg::ADDR_DECEL_TIME, 16'h0064);
    rd(4'hf, 16'h0000);
    wr(sfs_pkg::ADDR_CTRL, 16'h0011);
    rd(sfs_pkg::ADDR_CTRL, 16'h0012);
    wr(sfs_pkg::ADDR_DECEL_TIME, 16'h0001);
    wr(sfs_pkg::ADDR_RATED_SPEED, 16'd3000);
    rd(sfs_pkg::ADDR_RATED_SPEED, 16'd3000);
    run_up();
    acc(1'b1);
    @(posedge mclk);
    motor_speed <= 16'd5000;
    stop_req <= 1'b1;
    wait_on(1, 8);
    chk(cmd_speed, 16'd5000);
    look(3'b110);
    rd(sfs_pkg::ADDR_WARN_CODE, 16'h00e6);
    rd(sfs_pkg::ADDR_CMD_SPEED, 16'd5000);
    acc(1'b0);
    exp_spd = 5000;
    repeat (2) begin
      last = exp_spd[15:0];
      wait_on(2, 40100);
      exp_spd = exp_spd > 3000 / 1 ? exp_spd - 3000 / 1 : 0;
      chk(cmd_speed, exp_spd[15:0]);
    end
    look(3'b110);
    rd(sfs_pkg::ADDR_STATUS, 16'h0392);
    @(posedge mclk);
    motor_speed <= 16'd50;
    look(3'b110);
    @(posedge mclk);
    motor_speed <= 16'd49;
    wait_on(3, 8);
    look(3'b001);
    chk({15'h0000, zero_speed_detect}, 16'h0001);
    run_up();
    @(posedge mclk);
    motor_speed <= 16'd3000;
    qs_req <= 1'b1;
    wait_on(1, 8);
    look(3'b110);
    fail_in(5'b10100);
    look(3'b001);
    run_up();
    @(posedge mclk);
    torque_mode <= 1'b1;
    stop_req <= 1'b1;
    wait_on(1, 8);
    look(3'b001);
    run_up();
    @(posedge mclk);
    motor_speed <= 16'd3000;
    fail_in(5'b10000);
    wait_on(1, 8);
    look(3'b110);
    chk({15'h0000, fault_output}, 16'h0000);
    fail_in(5'b10100);
    wait_on(3, 8);
    run_up();
    fail_in(5'b11000);
    wait_on(1, 8);
    look(3'b001);
    run_up();
    @(posedge mclk);
    motor_speed <= 16'd3000;
    fail_in(5'b00010);
    wait_on(1, 8);
    look(3'b110);
    fail_in(5'b00011);
    look(3'b001);
    run_up();
    wr(sfs_pkg::ADDR_CTRL, 16'h0010);
    fail_in(5'b10000);
    wait_on(1, 8);
    look(3'b001);
    run_up();
    fail_in(5'b00010);
    wait_on(1, 8);
    look(3'b001);
    run_up();
    @(posedge mclk);
    stop_req <= 1'b1;
    repeat (8) @(posedge mclk);
    #1 chk({15'h0000, base_drive_on}, 16'h0001);
    @(posedge mclk);
    forced_stop_input_a <= 1'b0;
    wait_on(1, 8);
    look(3'b001);
    run_up();
    wr(sfs_pkg::ADDR_CTRL, 16'h0002);
    fail_in(5'b11000);
    wait_on(1, 8);
    look(3'b000);
    run_up();
    @(posedge mclk);
    off_req <= 1'b1;
    repeat (12) @(posedge mclk);
    #1 chk({15'h0000, base_drive_on}, 16'h0000);
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
